// [rtl/nverc_core.sv]
// execute and read command handler of the boot loader service
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "nverc_map.svh"

module nverc_core
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic rx_valid,
   input wire logic rx_sof,
   input wire logic [7:0] rx_byte,
   input wire logic tx_ready,
   output logic tx_valid,
   output logic tx_sof,
   output logic tx_last,
   output logic [7:0] tx_byte,
   output logic nvm_rd_req,
   output logic [31:0] nvm_rd_addr,
   input wire logic [7:0] nvm_rd_data,
   input wire logic nvm_nonlinear,
   input wire logic nvm_page_mapped,
   input wire logic hw_read_protect,
   output logic exec_go,
   output nverc_pkg::nverc_exec_t exec_info,
   output logic clk_to_pll,
   output logic irq_clear,
   output logic timer_clear,
   output logic watchdog_off,
   output logic err_valid,
   output nverc_pkg::nverc_err_t err_code
);

   nverc_pkg::nverc_state_t state_r;
   nverc_pkg::nverc_hdr_t hdr_in;
   nverc_pkg::nverc_hdr_t hdr_r;
   nverc_pkg::nverc_err_t err_nxt;
   logic hdr_in_valid;
   logic [1:0] ctrl_r;
   logic [7:0] remain_r;
   logic [7:0] blk_cnt_r;
   logic eot_r;
   logic [7:0] data_r;
   logic slot_free;
   logic is_exec;
   logic is_read;
   logic is_ours;
   logic bad_count;
   logic [7:0] blk_n;
   logic blk_eot;
   logic [31:0] stat_w;
   logic [31:0] rdata_nxt;

   function automatic logic hdr_is(input nverc_pkg::nverc_hdr_t h,
                                   input logic [7:0] len,
                                   input logic [7:0] mtype);
      hdr_is = (h.len == len) && (h.mtype == mtype);
   endfunction

   // ---------------------------------------------------------------
   // header collection
   // ---------------------------------------------------------------
   nverc_hdr_rx u_hdr_rx
   (
      .clk_sys(clk_sys),
      .srst(srst),
      .rx_valid(rx_valid),
      .rx_sof(rx_sof),
      .rx_byte(rx_byte),
      .hdr_valid(hdr_in_valid),
      .hdr(hdr_in)
   );

   // ---------------------------------------------------------------
   // header checks
   // ---------------------------------------------------------------
   assign is_exec = hdr_is(hdr_r, `NVERC_EXEC_LEN, `NVERC_EXEC_TYPE);
   assign is_read = hdr_is(hdr_r, `NVERC_READ_LEN, `NVERC_READ_TYPE);
   assign is_ours = (hdr_r.mtype == `NVERC_EXEC_TYPE) || (hdr_r.mtype == `NVERC_READ_TYPE);
   assign bad_count = is_read
                      && (hdr_r.count == 8'h00 || hdr_r.count > `NVERC_RD_MAX);

   // wrong length, then protection, then mapping
   assign err_nxt = (!(is_exec || is_read) || bad_count) ? nverc_pkg::ERR_PARAM :
                    hw_read_protect ? nverc_pkg::ERR_READ_PROT :
                    (is_read && nvm_nonlinear && !nvm_page_mapped) ?
                       nverc_pkg::ERR_NOT_MAPPED :
                    nverc_pkg::ERR_NONE;

   // ---------------------------------------------------------------
   // block sizing for read answers
   // ---------------------------------------------------------------
   assign slot_free = !tx_valid || tx_ready;
   assign blk_eot = ctrl_r[`NVERC_CTRL_ACCEL] || (remain_r <= `NVERC_STD_BLK);
   assign blk_n = blk_eot ? remain_r : `NVERC_STD_BLK;

   // ---------------------------------------------------------------
   // command sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         state_r <= nverc_pkg::ST_IDLE;
         hdr_r <= '0;
         remain_r <= 8'h00;
         blk_cnt_r <= 8'h00;
         eot_r <= 1'b0;
         data_r <= 8'h00;
         tx_valid <= 1'b0;
         tx_sof <= 1'b0;
         tx_last <= 1'b0;
         tx_byte <= 8'h00;
         nvm_rd_req <= 1'b0;
         nvm_rd_addr <= 32'h0000_0000;
         exec_go <= 1'b0;
         exec_info <= '0;
         clk_to_pll <= 1'b0;
         irq_clear <= 1'b0;
         timer_clear <= 1'b0;
         err_valid <= 1'b0;
         err_code <= nverc_pkg::ERR_NONE;
      end
      else
      begin
         nvm_rd_req <= 1'b0;
         exec_go <= 1'b0;
         irq_clear <= 1'b0;
         timer_clear <= 1'b0;
         err_valid <= 1'b0;
         if (tx_ready)
            tx_valid <= 1'b0;
         unique case (state_r)
            nverc_pkg::ST_IDLE:
            begin
               if (hdr_in_valid && ctrl_r[`NVERC_CTRL_EN])
               begin
                  hdr_r <= hdr_in;
                  nvm_rd_addr <= `NVERC_NVM_BASE + {8'h00, hdr_in.offset};
                  state_r <= nverc_pkg::ST_CHECK;
               end
            end
            nverc_pkg::ST_CHECK:
            begin
               err_code <= err_nxt;
               remain_r <= hdr_r.count;
               if (!is_ours)
                  state_r <= nverc_pkg::ST_IDLE;
               else if (err_nxt != nverc_pkg::ERR_NONE)
                  state_r <= nverc_pkg::ST_ERR;
               else if (is_exec)
                  state_r <= nverc_pkg::ST_EX_PREP;
               else
                  state_r <= nverc_pkg::ST_RD_LEN;
            end
            nverc_pkg::ST_ERR:
            begin
               err_valid <= 1'b1;
               state_r <= nverc_pkg::ST_IDLE;
            end
            nverc_pkg::ST_EX_PREP:
            begin
               clk_to_pll <= 1'b1;
               irq_clear <= 1'b1;
               timer_clear <= 1'b1;
               exec_info.target <= nvm_rd_addr;
               exec_info.stack_ptr <= `NVERC_STACK_INIT;
               exec_info.return_addr <= 32'h0000_0000;
               exec_info.vector_bypass_select <= `NVERC_VBS_NVM;
               state_r <= nverc_pkg::ST_EX_JUMP;
            end
            nverc_pkg::ST_EX_JUMP:
            begin
               exec_go <= 1'b1;
               state_r <= nverc_pkg::ST_HALT;
            end
            nverc_pkg::ST_HALT:
               state_r <= nverc_pkg::ST_HALT;
            nverc_pkg::ST_RD_LEN:
            begin
               if (slot_free)
               begin
                  tx_valid <= 1'b1;
                  tx_sof <= 1'b1;
                  tx_last <= 1'b0;
                  tx_byte <= blk_eot ? blk_n + 8'h01 : `NVERC_DATA_LEN;
                  blk_cnt_r <= blk_n;
                  eot_r <= blk_eot;
                  state_r <= nverc_pkg::ST_RD_TYPE;
               end
            end
            nverc_pkg::ST_RD_TYPE:
            begin
               if (slot_free)
               begin
                  tx_valid <= 1'b1;
                  tx_sof <= 1'b0;
                  tx_byte <= eot_r ? `NVERC_EOT_TYPE : `NVERC_DATA_TYPE;
                  state_r <= nverc_pkg::ST_RD_FETCH;
               end
            end
            nverc_pkg::ST_RD_FETCH:
            begin
               nvm_rd_req <= 1'b1;
               state_r <= nverc_pkg::ST_RD_WAIT;
            end
            nverc_pkg::ST_RD_WAIT:
               state_r <= nverc_pkg::ST_RD_CAP;
            nverc_pkg::ST_RD_CAP:
            begin
               data_r <= nvm_rd_data;
               state_r <= nverc_pkg::ST_RD_SEND;
            end
            nverc_pkg::ST_RD_SEND:
            begin
               if (slot_free)
               begin
                  tx_valid <= 1'b1;
                  tx_sof <= 1'b0;
                  tx_byte <= data_r;
                  tx_last <= (blk_cnt_r == 8'h01);
                  nvm_rd_addr <= nvm_rd_addr + 32'h0000_0001;
                  remain_r <= remain_r - 8'h01;
                  blk_cnt_r <= blk_cnt_r - 8'h01;
                  if (blk_cnt_r != 8'h01)
                     state_r <= nverc_pkg::ST_RD_FETCH;
                  else if (eot_r)
                     state_r <= nverc_pkg::ST_IDLE;
                  else
                     state_r <= nverc_pkg::ST_RD_LEN;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // register port
   // ---------------------------------------------------------------
   assign stat_w = {22'h00_0000, hw_read_protect, err_code, state_r == nverc_pkg::ST_HALT,
                    state_r != nverc_pkg::ST_IDLE, state_r};
   assign rdata_nxt = !reg_rd ? 32'h0000_0000 :
                      (reg_addr == `NVERC_REG_CTRL) ? {30'h0000_0000, ctrl_r} :
                      (reg_addr == `NVERC_REG_STAT) ? stat_w :
                      32'h0000_0000;

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         ctrl_r <= `NVERC_CTRL_RST;
         reg_rdata <= 32'h0000_0000;
         watchdog_off <= 1'b1;
      end
      else
      begin
         watchdog_off <= 1'b1;
         reg_rdata <= rdata_nxt;
         if (reg_wr && reg_addr == `NVERC_REG_CTRL)
            ctrl_r <= reg_wdata[1:0];
      end
   end

endmodule // nverc_core
`default_nettype wire

// [rtl/nverc_map.svh]
// offsets, field values and limits of the execute and read command handler
//
// How it works
// - execute header: length 04h, type 86h, then three address bytes
// - 24-bit offset, MSB first, added to NVM base 1100_0000h gives target
// - jump goes ahead with no check for valid code at the target
// - execute sends no response; execution starts right after the header
// - stack pointer loaded with 1800_0400h before the jump
// - before jump: clock to PLL, interrupts and timer cleared, bypass 10b
// - return address cleared to zero; only a system reset re-enters the loader
// - watchdog stays disabled when control passes to NVM code
// - execute refused while hardware read protection is active
// - read header: length 06h, type 87h, offset MSB first, reserved, count
// - one read returns at most 128 bytes; host splits larger transfers
// - read data sent in data blocks, then one end-of-transfer block
// - data block: length 06h, type 00h, read data in bytes 2 to 6
// - data blocks only on standard bus; accelerated variant uses one final block
// - read refused while hardware read protection is active
// - read of an unmapped page in the non-linear region is refused
// - final block type 80h, data at most 5 standard or 128 accelerated
// - on standard bus the final block length lies between 2 and 6
`ifndef NVERC_MAP_SVH
`define NVERC_MAP_SVH

`define NVERC_EXEC_LEN 8'h04
`define NVERC_EXEC_TYPE 8'h86
`define NVERC_READ_LEN 8'h06
`define NVERC_READ_TYPE 8'h87
`define NVERC_DATA_LEN 8'h06
`define NVERC_DATA_TYPE 8'h00
`define NVERC_EOT_TYPE 8'h80
`define NVERC_NVM_BASE 32'h1100_0000
`define NVERC_STACK_INIT 32'h1800_0400
`define NVERC_VBS_NVM 2'h2
`define NVERC_RD_MAX 8'h80
`define NVERC_STD_BLK 8'h05
`define NVERC_HDR_LAST 3'h6

`define NVERC_REG_CTRL 4'h0
`define NVERC_REG_STAT 4'h4
`define NVERC_CTRL_ACCEL 0
`define NVERC_CTRL_EN 1
`define NVERC_CTRL_RST 2'h2

`endif

// [rtl/nverc_pkg.sv]
// types of the execute and read command handler
package nverc_pkg;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_CHECK = 4'h1,
      ST_ERR = 4'h2,
      ST_EX_PREP = 4'h3,
      ST_EX_JUMP = 4'h4,
      ST_HALT = 4'h5,
      ST_RD_LEN = 4'h6,
      ST_RD_TYPE = 4'h7,
      ST_RD_FETCH = 4'h8,
      ST_RD_WAIT = 4'h9,
      ST_RD_CAP = 4'ha,
      ST_RD_SEND = 4'hb
   } nverc_state_t;

   typedef enum logic [2:0] {
      ERR_NONE = 3'h0,
      ERR_READ_PROT = 3'h1,
      ERR_PARAM = 3'h2,
      ERR_NOT_MAPPED = 3'h3
   } nverc_err_t;

   typedef struct packed {
      logic [7:0] len;
      logic [7:0] mtype;
      logic [23:0] offset;
      logic [7:0] rsvd;
      logic [7:0] count;
   } nverc_hdr_t;

   typedef struct packed {
      logic [31:0] target;
      logic [31:0] stack_ptr;
      logic [31:0] return_addr;
      logic [1:0] vector_bypass_select;
   } nverc_exec_t;

endpackage

// [rtl/nverc_hdr_rx.sv]
// header block collector for incoming link bytes
`timescale 1ns/100ps
`default_nettype none
`include "nverc_map.svh"

module nverc_hdr_rx
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic rx_valid,
   input wire logic rx_sof,
   input wire logic [7:0] rx_byte,
   output logic hdr_valid,
   output nverc_pkg::nverc_hdr_t hdr
);

   logic [7:0] byte_r [0:6];
   logic [2:0] idx_r;
   logic active_r;
   logic [2:0] idx_cur;
   logic [7:0] len_cur;
   logic done_w;

   // ---------------------------------------------------------------
   // byte position and end of header
   // ---------------------------------------------------------------
   assign idx_cur = rx_sof ? 3'h0 : idx_r;
   assign len_cur = rx_sof ? rx_byte : byte_r[0];
   assign done_w = rx_valid && (rx_sof || active_r)
                   && ((len_cur[2:0] == idx_cur && len_cur[7:3] == 5'h00)
                       || idx_cur == `NVERC_HDR_LAST);

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         idx_r <= 3'h0;
         active_r <= 1'b0;
         hdr_valid <= 1'b0;
      end
      else
      begin
         hdr_valid <= done_w;
         if (rx_valid && (rx_sof || active_r))
         begin
            idx_r <= idx_cur + 3'h1;
            active_r <= !done_w;
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rx_valid && (rx_sof || active_r))
         byte_r[idx_cur] <= rx_byte;
   end

   // fields appear once the last byte is stored
   assign hdr.len = byte_r[0];
   assign hdr.mtype = byte_r[1];
   assign hdr.offset = {byte_r[2], byte_r[3], byte_r[4]};
   assign hdr.rsvd = byte_r[5];
   assign hdr.count = byte_r[6];

endmodule // nverc_hdr_rx
`default_nettype wire

// [test/nverc_chk.sv]
// port assertions for the execute and read command handler
`timescale 1ns/100ps
`default_nettype none
module nverc_chk
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic tx_sof,
   input wire logic tx_last,
   input wire logic [7:0] tx_byte,
   input wire logic nvm_rd_req,
   input wire logic [31:0] nvm_rd_addr,
   input wire logic hw_read_protect,
   input wire logic exec_go,
   input wire nverc_pkg::nverc_exec_t exec_info,
   input wire logic clk_to_pll,
   input wire logic irq_clear,
   input wire logic timer_clear,
   input wire logic watchdog_off,
   input wire logic err_valid,
   input wire nverc_pkg::nverc_err_t err_code
);
   // ----
   // block byte position tracking
   // ----
   logic [7:0] idx_r;
   logic [7:0] len_r;
   always_ff @(posedge clk_sys)
      if (srst)
         idx_r <= 8'h00;
      else if (tx_valid && tx_ready)
         idx_r <= tx_sof ? 8'h01 : idx_r + 8'h01;
   always_ff @(posedge clk_sys)
      if (tx_valid && tx_ready && tx_sof)
         len_r <= tx_byte;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   sequence take_s;
      tx_valid && tx_ready;
   endsequence
   sequence prep_s;
      irq_clear && timer_clear && clk_to_pll;
   endsequence
   stack_init_a: assert property (exec_go |-> exec_info.stack_ptr == 32'h1800_0400)
      else $error("stack pointer wrong at jump");
   ret_zero_a: assert property (exec_go |-> exec_info.return_addr == 32'h0000_0000)
      else $error("return address not zero at jump");
   prep_jump_a: assert property (prep_s |=> exec_go && exec_info.vector_bypass_select == 2'h2)
      else $error("jump does not follow preparation");
   jump_prep_a: assert property (exec_go |-> $past(irq_clear) && $past(timer_clear))
      else $error("jump without preparation");
   halt_after_a: assert property (exec_go |=> (!exec_go && !tx_valid && !nvm_rd_req)[*8])
      else $error("activity after jump");
   wdog_off_a: assert property (watchdog_off)
      else $error("watchdog enabled");
   no_exec_prot_a: assert property (exec_go |-> !hw_read_protect)
      else $error("jump while protected");
   nvm_base_a: assert property (nvm_rd_req |-> nvm_rd_addr[31:24] == 8'h11)
      else $error("read address outside base");
   blk_type_a: assert property (take_s ##0 (idx_r == 8'h01) |-> tx_byte inside {8'h00, 8'h80})
      else $error("bad block type");
   data_len_a: assert property (take_s ##0 (idx_r == 8'h01 && tx_byte == 8'h00) |-> len_r == 8'h06)
      else $error("bad data block length");
   last_pos_a: assert property (take_s ##0 tx_last |-> idx_r == len_r)
      else $error("block end does not match length");
   err_code_a: assert property (err_valid |-> err_code != nverc_pkg::ERR_NONE)
      else $error("error pulse without code");
endmodule // nverc_chk
bind nverc_core nverc_chk i_chk (.clk_sys, .srst, .tx_valid, .tx_ready, .tx_sof, .tx_last,
   .tx_byte, .nvm_rd_req, .nvm_rd_addr, .hw_read_protect, .exec_go, .exec_info, .clk_to_pll,
   .irq_clear, .timer_clear, .watchdog_off, .err_valid, .err_code);
`default_nettype wire

// [test/nverc_host_model.sv]
// boot host model on the serial link side
`timescale 1ns/100ps
`default_nettype none
module nverc_host_model
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic slow,
   output logic rx_valid,
   output logic rx_sof,
   output logic [7:0] rx_byte,
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   output logic tx_ready
);
   // ----
   // header sender and answer collector
   // ----
   // scaled stand-in for the host's wait after a request
   localparam int HOST_WAIT = 16;
   logic [7:0] got[$];
   logic rx_d;
   int wait_cnt;
   initial
   begin
      rx_valid = 1'b0;
      rx_sof = 1'b0;
      rx_byte = 8'h00;
      tx_ready = 1'b1;
      rx_d = 1'b0;
      wait_cnt = 0;
   end
   // answer taken only after the wait that follows each request
   always @(posedge clk_sys)
   begin
      rx_d <= rx_valid;
      if (rx_d && !rx_valid)
         wait_cnt <= HOST_WAIT;
      else if (wait_cnt != 0)
         wait_cnt <= wait_cnt - 1;
      tx_ready <= (wait_cnt == 0) && (slow ? !tx_ready : 1'b1);
      if (!srst && tx_valid && tx_ready)
         got.push_back(tx_byte);
   end
   // whole header, length byte first
   task automatic send(input logic [7:0] b[$]);
      for (int i = 0; i < b.size(); i++)
      begin
         @(posedge clk_sys);
         rx_valid <= 1'b1;
         rx_sof <= (i == 0);
         rx_byte <= b[i];
      end
      @(posedge clk_sys);
      rx_valid <= 1'b0;
      rx_sof <= 1'b0;
      rx_byte <= ~b[b.size() - 1];
   endtask
endmodule // nverc_host_model
`default_nettype wire

// [test/testbench.sv]
// self-checking bench of the execute and read command handler
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk_sys, srst, reg_wr, reg_rd, rx_valid, rx_sof, tx_ready, tx_valid, tx_sof, tx_last;
   logic nvm_rd_req, nvm_nonlinear, nvm_page_mapped, hw_read_protect, exec_go, slow;
   logic clk_to_pll, irq_clear, timer_clear, watchdog_off, err_valid;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, nvm_rd_addr, q;
   logic [7:0] rx_byte, tx_byte, nvm_rd_data;
   nverc_pkg::nverc_exec_t exec_info;
   nverc_pkg::nverc_err_t err_code;
   int fail_count = 0;
   int total_checks = 0;
   int jumps = 0;
   int errs = 0;
   nverc_core i_dut (.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .rx_valid, .rx_sof, .rx_byte, .tx_ready, .tx_valid, .tx_sof, .tx_last, .tx_byte,
      .nvm_rd_req, .nvm_rd_addr, .nvm_rd_data, .nvm_nonlinear, .nvm_page_mapped,
      .hw_read_protect, .exec_go, .exec_info, .clk_to_pll, .irq_clear, .timer_clear,
      .watchdog_off, .err_valid, .err_code);
   nverc_host_model u_host (.clk_sys, .srst, .slow, .rx_valid, .rx_sof, .rx_byte,
      .tx_valid, .tx_byte, .tx_ready);
   // ----
   // memory model and helpers
   // ----
   always @(posedge clk_sys)
   begin
      nvm_rd_data <= nvm_rd_req ? (nvm_rd_addr[7:0] ^ 8'h5a) : ~nvm_rd_data;
      if (exec_go === 1'b1)
         jumps++;
      if (err_valid === 1'b1)
         errs++;
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e)
      begin
         fail_count++;
         $display("MISMATCH %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic rw(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= wr;
      reg_rd <= !wr;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask
   task automatic read_t(input logic [23:0] off, input int cnt, input logic accel);
      logic [7:0] e[$];
      int k;
      int blk;
      logic last;
      k = 0;
      u_host.got = {};
      while (k < cnt)
      begin
         last = accel || cnt - k <= 5;
         blk = last ? cnt - k : 5;
         e.push_back(8'(blk + 1));
         e.push_back(last ? 8'h80 : 8'h00);
         for (int j = 0; j < blk; j++)
            e.push_back(8'(off + k + j) ^ 8'h5a);
         k += blk;
      end
      u_host.send('{8'h06, 8'h87, off[23:16], off[15:8], off[7:0], 8'h00, 8'(cnt)});
      for (int t = 0; t < 2000 && u_host.got.size() < e.size(); t++)
         @(posedge clk_sys);
      repeat (4) @(posedge clk_sys);
      chk("answer size", u_host.got.size(), e.size());
      for (int i = 0; i < e.size() && i < u_host.got.size(); i++)
         chk("answer byte", u_host.got[i], e[i]);
   endtask
   task automatic err_t(input logic [7:0] h[$], input nverc_pkg::nverc_err_t ec);
      u_host.got = {};
      u_host.send(h);
      for (int t = 0; t < 10 && err_valid !== 1'b1; t++)
         @(posedge clk_sys) #1;
      chk("err code", {err_valid, 1'b0, err_code}, {2'h2, ec});
      repeat (24) @(posedge clk_sys);
      chk("no answer", u_host.got.size() + jumps, 0);
   endtask
   task automatic ignore_t(input logic [7:0] h[$]);
      int e0;
      e0 = errs;
      u_host.got = {};
      u_host.send(h);
      repeat (40) @(posedge clk_sys);
      chk("ignored", u_host.got.size() + errs - e0, 0);
   endtask
   task automatic exec_t(input logic [23:0] off);
      u_host.got = {};
      u_host.send('{8'h04, 8'h86, off[23:16], off[15:8], off[7:0]});
      for (int t = 0; t < 12 && exec_go !== 1'b1; t++)
         @(posedge clk_sys) #1;
      chk("jump", exec_go, 1);
      chk("target", exec_info.target, 32'h1100_0000 + off);
      chk("stack", exec_info.stack_ptr, 32'h1800_0400);
      chk("ret addr", exec_info.return_addr, 32'h0000_0000);
      chk("bypass", {clk_to_pll, exec_info.vector_bypass_select}, 3'h6);
      chk("watchdog", watchdog_off, 1);
      u_host.send('{8'h06, 8'h87, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01});
      repeat (40) @(posedge clk_sys);
      chk("halted", u_host.got.size(), 0);
   endtask
   task automatic final_report;
      if (fail_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // ----
   // main sequence
   // ----
   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial
   begin
      #100000;
      fail_count++;
      final_report;
   end
   initial
   begin
      srst = 1'b1;
      {reg_wr, reg_rd, reg_addr, reg_wdata, nvm_rd_data} = '0;
      {nvm_nonlinear, nvm_page_mapped, hw_read_protect, slow} = 4'h4;
      repeat (6) @(posedge clk_sys);
      srst <= 1'b0;
      rw(1'b0, 4'h0, 32'h0);
      chk("ctrl reset", q, 32'h2);
      rw(1'b0, 4'h8, 32'h0);
      chk("unmapped", q, 32'h0);
      read_t(24'h00_0010, 1, 1'b0);
      read_t(24'h00_0020, 5, 1'b0);
      slow <= 1'b1;
      read_t(24'h01_00f0, 7, 1'b0);
      slow <= 1'b0;
      rw(1'b1, 4'h0, 32'h3);
      read_t(24'h00_0040, 12, 1'b1);
      err_t('{8'h06, 8'h87, 8'h00, 8'h00, 8'h00, 8'h00, 8'h81}, nverc_pkg::ERR_PARAM);
      rw(1'b1, 4'h0, 32'h2);
      ignore_t('{8'h05, 8'h88, 8'h00, 8'h00, 8'h00, 8'h00});
      rw(1'b1, 4'h0, 32'h0);
      ignore_t('{8'h06, 8'h87, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01});
      rw(1'b1, 4'h0, 32'h2);
      err_t('{8'h05, 8'h87, 8'h00, 8'h00, 8'h00, 8'h00}, nverc_pkg::ERR_PARAM);
      err_t('{8'h03, 8'h86, 8'h00, 8'h00}, nverc_pkg::ERR_PARAM);
      nvm_nonlinear <= 1'b1;
      nvm_page_mapped <= 1'b0;
      err_t('{8'h06, 8'h87, 8'h00, 8'h30, 8'h00, 8'h00, 8'h04}, nverc_pkg::ERR_NOT_MAPPED);
      nvm_nonlinear <= 1'b0;
      nvm_page_mapped <= 1'b1;
      hw_read_protect <= 1'b1;
      rw(1'b0, 4'h4, 32'h0);
      chk("stat protect", q[9], 1);
      err_t('{8'h06, 8'h87, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02}, nverc_pkg::ERR_READ_PROT);
      err_t('{8'h04, 8'h86, 8'h00, 8'h01, 8'h00}, nverc_pkg::ERR_READ_PROT);
      hw_read_protect <= 1'b0;
      exec_t(24'h00_1234);
      final_report;
   end
endmodule // testbench
`default_nettype wire
